// File: serial_host_port_defines.svh
// Purpose: Constants for the serial host port and command ring.
// Assumes: Included by bare name from the serial_host_port_cmd_fifo design module only.
// Notes: Addresses are byte addresses inside the register region.
`ifndef SERIAL_HOST_PORT_DEFINES_SVH
`define SERIAL_HOST_PORT_DEFINES_SVH

// Link width field
`define WIDTH_RESET 2'h0
`define WIDTH_RESERVED 2'h3

// Register region byte addresses
`define REG_WIDTH_ADDR 12'h000
`define REG_WRPTR_LO_ADDR 12'h004
`define REG_WRPTR_HI_ADDR 12'h005
`define REG_RDPTR_LO_ADDR 12'h008
`define REG_RDPTR_HI_ADDR 12'h009

// Command ring geometry, 4 Kbyte
`define RING_BYTES 4096
`define RING_PTR_W 12
`define PTR_RESET 12'h000

// Transaction header bits (16-bit header, first byte most significant)
`define HDR_READ_BIT 7
`define HDR_RING_BIT 6
`define HDR_ADDR_HI_MSB 3

// Bit counter last values per width
`define LAST_SINGLE 3'h7
`define LAST_DUAL 3'h3
`define LAST_QUAD 3'h1

// Fetch buffer geometry
`define FETCH_FIFO_DEPTH 16
`define FETCH_FIFO_WIDTH 8

`endif

// File: serial_host_port_pkg.sv
// Purpose: Types shared by the serial host port modules.
// Assumes: serial_host_port_defines.svh holds the numeric constants.
// Notes: One-hot transaction phases.
package serial_host_port_pkg;

    // Active data-line width
    typedef enum logic [1:0] {
        WIDTH_SINGLE = 2'h0,
        WIDTH_DUAL = 2'h1,
        WIDTH_QUAD = 2'h2,
        WIDTH_RSVD = 2'h3
    } width_t;

    // Transaction phase
    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_HDR0 = 4'h2,
        PH_HDR1 = 4'h4,
        PH_DATA = 4'h8
    } phase_t;

    // Decoded transaction header
    typedef struct packed {
        logic rd;
        logic ring;
        logic [11:0] addr;
    } hdr_t;

    // Pin group of the data lines
    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] oe;
    } pins_t;

endpackage

// File: stream_fifo.sv
// Purpose: Valid/ready FIFO with registered read data.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Output stage is a register, so capacity is DEPTH plus one.
`timescale 1ns/1ns
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_idx_r;
    logic [AW-1:0] rd_idx_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // Handshake decode
    assign o_in_ready = (count_r != (AW+1)'(DEPTH));
    assign push = i_in_valid & o_in_ready;
    assign pop = (count_r != '0) & (~o_out_valid | i_out_ready);

    // Storage write
    always_ff @(posedge i_core_clk)
    begin
        if (push)
            mem_r[wr_idx_r] <= i_in_data;
    end

    // Pointers and fill count
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
                wr_idx_r <= wr_idx_r + 1'b1;
            if (pop)
                rd_idx_r <= rd_idx_r + 1'b1;
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered output stage
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            o_out_valid <= 1'b0;
            o_out_data <= '0;
        end
        else if (pop)
        begin
            o_out_valid <= 1'b1;
            o_out_data <= mem_r[rd_idx_r];
        end
        else if (i_out_ready)
            o_out_valid <= 1'b0;
    end
endmodule

// File: serial_host_port_cmd_fifo.sv
// Purpose: Serial slave port with link width select and command ring.
// Assumes: Link clock and pins are sampled by i_core_clk through two flops.
// Notes: Link clock must stay well below a quarter of the core clock.
//
// How it works
// - Reset gives single line, MOSI in, MISO out
// - Single mode samples line 0, drives line 1
// - Width register written over the active mode
// - Width codes 00/01/10, 11 ignored; host limits
// - 4 Kbyte command ring filled by host
// - Engine fetches pending commands in order
// - Read pointer advances only after execution
// - Quad lines 2,3 take the general IO pins
`timescale 1ns/1ns
`include "serial_host_port_defines.svh"
module serial_host_port_cmd_fifo
    import serial_host_port_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io,
    output logic [3:0] o_io,
    output logic [3:0] o_io_oe,
    input wire logic [1:0] i_general_io_drive,
    input wire logic [1:0] i_general_io_oe,
    output logic o_cmd_valid,
    input wire logic i_cmd_ready,
    output logic [7:0] o_cmd_data,
    input wire logic i_cmd_done,
    output logic [1:0] o_link_width,
    output logic o_cmd_pending
);
    // Next shifted byte for the active width
    function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic [3:0] io,
                                            input width_t w);
        case (w)
            WIDTH_DUAL: shift_in = {sr[5:0], io[1:0]};
            WIDTH_QUAD: shift_in = {sr[3:0], io[3:0]};
            default: shift_in = {sr[6:0], io[0]};
        endcase
    endfunction

    // Bits driven for one chunk of an outgoing byte
    function automatic logic [3:0] chunk_out(input logic [7:0] b, input logic [2:0] n,
                                             input width_t w);
        logic [7:0] s;
        s = 8'h00;
        case (w)
            WIDTH_DUAL:
            begin
                s = b << {n[1:0], 1'b0};
                chunk_out = {2'b00, s[7:6]};
            end
            WIDTH_QUAD:
            begin
                s = b << {n[0], 2'b00};
                chunk_out = s[7:4];
            end
            default:
            begin
                s = b << n;
                chunk_out = {2'b00, s[7], 1'b0};
            end
        endcase
    endfunction

    // Last bit count of a byte for the active width
    function automatic logic [2:0] last_cnt(input width_t w);
        case (w)
            WIDTH_DUAL: last_cnt = `LAST_DUAL;
            WIDTH_QUAD: last_cnt = `LAST_QUAD;
            default: last_cnt = `LAST_SINGLE;
        endcase
    endfunction

    logic [2:0] sck_sync_r;
    logic [2:0] cs_sync_r;
    logic [3:0] io_meta_r;
    logic [3:0] io_sync_r;
    phase_t phase_r;
    phase_t phase_nxt;
    width_t width_r;
    width_t width_pend_r;
    logic [2:0] cnt_r;
    logic [7:0] sr_r;
    logic [7:0] hdr_hi_r;
    hdr_t hdr_r;
    logic [7:0] hold_r;
    logic [3:0] out_r;
    logic [7:0] wrptr_stage_r;
    logic [11:0] wr_ptr_r;
    logic [11:0] rd_ptr_r;
    logic [11:0] fetch_ptr_r;
    logic inflight_r;
    logic [7:0] ring_r [`RING_BYTES];
    logic [7:0] ring_host_q_r;
    logic [7:0] ring_fetch_q_r;
    logic [7:0] reg_rd;
    logic [7:0] rd_mux;
    logic [7:0] rx_byte;
    logic sck_rise;
    logic sck_fall;
    logic cs_active;
    logic cs_end;
    logic byte_done;
    logic data_wr;
    logic reg_wr;
    logic ring_wr;
    logic rd_drive;
    logic fifo_in_ready;
    logic fetch_issue;
    logic retire;
    pins_t pins;

    // Two-flop synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            sck_sync_r <= 3'h0;
            cs_sync_r <= 3'h7;
            io_meta_r <= 4'h0;
            io_sync_r <= 4'h0;
        end
        else
        begin
            sck_sync_r <= {sck_sync_r[1:0], i_sck};
            cs_sync_r <= {cs_sync_r[1:0], i_cs_n};
            io_meta_r <= i_io;
            io_sync_r <= io_meta_r;
        end
    end

    // Link edge and frame decode
    assign sck_rise = sck_sync_r[1] & ~sck_sync_r[2];
    assign sck_fall = ~sck_sync_r[1] & sck_sync_r[2];
    assign cs_active = ~cs_sync_r[1];
    assign cs_end = cs_sync_r[1] & ~cs_sync_r[2];
    assign rx_byte = shift_in(sr_r, io_sync_r, width_r);
    assign byte_done = sck_rise & cs_active & (cnt_r == last_cnt(width_r));
    assign data_wr = (phase_r == PH_DATA) & byte_done & ~hdr_r.rd;
    assign reg_wr = data_wr & ~hdr_r.ring;
    assign ring_wr = data_wr & hdr_r.ring;

    // Phase sequencing
    always_comb
    begin
        phase_nxt = phase_r;
        case (phase_r)
            PH_IDLE: if (cs_active) phase_nxt = PH_HDR0;
            PH_HDR0: if (byte_done) phase_nxt = PH_HDR1;
            PH_HDR1: if (byte_done) phase_nxt = PH_DATA;
            PH_DATA: phase_nxt = PH_DATA;
            default: phase_nxt = PH_IDLE;
        endcase
        if (!cs_active)
            phase_nxt = PH_IDLE;
    end

    // Phase, bit counter and receive shifter
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            phase_r <= PH_IDLE;
            cnt_r <= 3'h0;
            sr_r <= 8'h00;
        end
        else
        begin
            phase_r <= phase_nxt;
            if (!cs_active)
                cnt_r <= 3'h0;
            else if (sck_rise)
                cnt_r <= byte_done ? 3'h0 : cnt_r + 3'h1;
            if (sck_rise & cs_active)
                sr_r <= rx_byte;
        end
    end

    // Header capture and address auto-increment
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            hdr_hi_r <= 8'h00;
            hdr_r <= '0;
        end
        else if (byte_done)
        begin
            if (phase_r == PH_HDR0)
                hdr_hi_r <= rx_byte;
            else if (phase_r == PH_HDR1)
            begin
                hdr_r.rd <= hdr_hi_r[`HDR_READ_BIT];
                hdr_r.ring <= hdr_hi_r[`HDR_RING_BIT];
                hdr_r.addr <= {hdr_hi_r[`HDR_ADDR_HI_MSB:0], rx_byte};
            end
            else if (phase_r == PH_DATA)
                hdr_r.addr <= hdr_r.addr + 12'h001;
        end
    end

    // Width register: written in the active mode, applied when the frame ends
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            width_pend_r <= width_t'(`WIDTH_RESET);
            width_r <= width_t'(`WIDTH_RESET);
        end
        else
        begin
            if (reg_wr && hdr_r.addr == `REG_WIDTH_ADDR && rx_byte[1:0] != `WIDTH_RESERVED)
                width_pend_r <= width_t'(rx_byte[1:0]);
            if (cs_end)
                width_r <= width_pend_r;
        end
    end

    // Host write pointer, committed when its high byte lands
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            wrptr_stage_r <= 8'h00;
            wr_ptr_r <= `PTR_RESET;
        end
        else if (reg_wr)
        begin
            if (hdr_r.addr == `REG_WRPTR_LO_ADDR)
                wrptr_stage_r <= rx_byte;
            if (hdr_r.addr == `REG_WRPTR_HI_ADDR)
                wr_ptr_r <= {rx_byte[3:0], wrptr_stage_r};
        end
    end

    // Command ring storage with host and fetch read registers
    always_ff @(posedge i_core_clk)
    begin
        if (ring_wr)
            ring_r[hdr_r.addr] <= rx_byte;
        ring_host_q_r <= ring_r[hdr_r.addr];
        ring_fetch_q_r <= ring_r[fetch_ptr_r];
    end

    // Register read decode and read source select
    assign reg_rd = (hdr_r.addr == `REG_WIDTH_ADDR) ? {6'h00, width_pend_r} :
                    (hdr_r.addr == `REG_WRPTR_LO_ADDR) ? wr_ptr_r[7:0] :
                    (hdr_r.addr == `REG_WRPTR_HI_ADDR) ? {4'h0, wr_ptr_r[11:8]} :
                    (hdr_r.addr == `REG_RDPTR_LO_ADDR) ? rd_ptr_r[7:0] :
                    (hdr_r.addr == `REG_RDPTR_HI_ADDR) ? {4'h0, rd_ptr_r[11:8]} : 8'h00;
    assign rd_mux = hdr_r.ring ? ring_host_q_r : reg_rd;
    assign rd_drive = (phase_r == PH_DATA) & hdr_r.rd & cs_active;

    // Outgoing chunk register, updated on link falling edges
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            hold_r <= 8'h00;
            out_r <= 4'h0;
        end
        else if (!cs_active)
            out_r <= 4'h0;
        else if (sck_fall && rd_drive)
        begin
            if (cnt_r == 3'h0)
            begin
                hold_r <= rd_mux;
                out_r <= chunk_out(rd_mux, cnt_r, width_r);
            end
            else
                out_r <= chunk_out(hold_r, cnt_r, width_r);
        end
    end

    // Pin drive per width; quad lines 2,3 borrow the general IO pins
    always_comb
    begin
        pins.dout = {i_general_io_drive, out_r[1:0]};
        pins.oe = {i_general_io_oe, cs_active, 1'b0};
        case (width_r)
            WIDTH_DUAL: pins.oe[1:0] = {2{rd_drive}};
            WIDTH_QUAD:
            begin
                pins.dout[3:2] = out_r[3:2];
                pins.oe = {4{rd_drive}};
            end
            default: pins.oe[0] = 1'b0;
        endcase
    end
    assign o_io = pins.dout;
    assign o_io_oe = pins.oe;

    // Fetch one pending byte at a time while the buffer has room
    assign fetch_issue = (fetch_ptr_r != wr_ptr_r) & fifo_in_ready & ~inflight_r;
    assign retire = i_cmd_done & (rd_ptr_r != fetch_ptr_r);

    // Fetch and read pointers
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            fetch_ptr_r <= `PTR_RESET;
            rd_ptr_r <= `PTR_RESET;
            inflight_r <= 1'b0;
        end
        else
        begin
            inflight_r <= fetch_issue;
            if (fetch_issue)
                fetch_ptr_r <= fetch_ptr_r + 12'h001;
            if (retire)
                rd_ptr_r <= rd_ptr_r + 12'h001;
        end
    end

    // Buffer between ring and graphics engine, in fetch order
    stream_fifo #(
        .WIDTH(`FETCH_FIFO_WIDTH),
        .DEPTH(`FETCH_FIFO_DEPTH)
    ) u_fetch_fifo (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(inflight_r),
        .o_in_ready(fifo_in_ready),
        .i_in_data(ring_fetch_q_r),
        .o_out_valid(o_cmd_valid),
        .i_out_ready(i_cmd_ready),
        .o_out_data(o_cmd_data)
    );

    // Status
    assign o_link_width = width_r;
    assign o_cmd_pending = (rd_ptr_r != wr_ptr_r);
endmodule

// File: serial_host_port_cmd_fifo_monitor.sv
// Purpose: Port assertions for the serial host port.
// Assumes: Bound to the top module; one core clock domain.
// Notes: Watches design ports only, inputs and outputs.
`timescale 1ns/1ns
module serial_host_port_cmd_fifo_monitor
    import serial_host_port_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io,
    input wire logic [3:0] o_io,
    input wire logic [3:0] o_io_oe,
    input wire logic [1:0] i_general_io_drive,
    input wire logic [1:0] i_general_io_oe,
    input wire logic o_cmd_valid,
    input wire logic i_cmd_ready,
    input wire logic [7:0] o_cmd_data,
    input wire logic i_cmd_done,
    input wire logic [1:0] o_link_width,
    input wire logic o_cmd_pending
);
    default clocking mc @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Reset, width and pin ownership
    AST_RST_STATE:
        assert property ($rose(i_rst_n) |-> o_link_width == 2'h0 && !o_cmd_valid && !o_cmd_pending)
        else $error("state not cleared by reset");
    AST_WIDTH_LEGAL:
        assert property (o_link_width != 2'h3)
        else $error("reserved width active");
    AST_WIDTH_AT_END:
        assert property ($changed(o_link_width) |-> i_cs_n && $past(i_cs_n, 2))
        else $error("width changed inside a frame");
    AST_SINGLE_IN:
        assert property (o_link_width == WIDTH_SINGLE |-> !o_io_oe[0])
        else $error("line 0 driven in single mode");
    AST_IDLE_OE:
        assert property (i_cs_n [*4] |-> o_io_oe[1:0] == 2'h0)
        else $error("lines driven while deselected");
    AST_GIO_PASS:
        assert property (o_link_width != WIDTH_QUAD |->
            o_io[3:2] == i_general_io_drive && o_io_oe[3:2] == i_general_io_oe)
        else $error("general pins not passed through");
    AST_QUAD_LINES:
        assert property (o_link_width == WIDTH_QUAD |-> o_io_oe == 4'h0 || o_io_oe == 4'hf)
        else $error("quad lines not driven together");
    // Command stream toward the engine
    AST_VALID_HOLD:
        assert property (o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd_data))
        else $error("command byte dropped before take");
    AST_EMPTY_QUIET:
        assert property (!o_cmd_pending |-> !o_cmd_valid)
        else $error("byte offered from empty ring");
    AST_RETIRE_DONE:
        assert property ($fell(o_cmd_pending) |-> $past(i_cmd_done) || $past(i_cmd_done, 2))
        else $error("ring emptied without completion");

    CV_QUAD: cover property (o_link_width == WIDTH_QUAD && !i_cs_n);
    CV_STALL: cover property (o_cmd_valid && !i_cmd_ready);
    CV_EMPTIED: cover property ($fell(o_cmd_pending));
endmodule

bind serial_host_port_cmd_fifo serial_host_port_cmd_fifo_monitor u_mon (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sck(i_sck), .i_cs_n(i_cs_n),
    .i_io(i_io), .o_io(o_io), .o_io_oe(o_io_oe), .i_general_io_drive(i_general_io_drive),
    .i_general_io_oe(i_general_io_oe), .o_cmd_valid(o_cmd_valid), .i_cmd_ready(i_cmd_ready),
    .o_cmd_data(o_cmd_data), .i_cmd_done(i_cmd_done), .o_link_width(o_link_width),
    .o_cmd_pending(o_cmd_pending));

// File: spi_host_model.sv
// Purpose: Behavioural serial master that drives the port.
// Assumes: Mode 0, link clock 800 ns, idle low.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/1ns
module spi_host_model
    import serial_host_port_pkg::*;
(
    input wire logic i_clk,
    input wire logic [3:0] i_io,
    output logic o_sck,
    output logic o_cs_n,
    output logic [3:0] o_io,
    output logic [3:0] o_oe
);
    width_t w = WIDTH_SINGLE; // Width in force, set by the bench
    logic [7:0] wq[$];
    logic [7:0] rq[$];

    // Idle lines
    initial
    begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_io = 4'h0;
        o_oe = 4'h0;
    end

    // One byte, top chunk first; change on fall, sample two cycles after rise
    task automatic xbyte(input logic [7:0] b, input logic rd);
        int n;
        logic [3:0] m;
        logic [7:0] r;
        n = (w == WIDTH_QUAD) ? 4 : (w == WIDTH_DUAL) ? 2 : 1;
        m = 4'((1 << n) - 1);
        r = 8'h00;
        for (int i = 8 / n - 1; i >= 0; i--)
        begin
            o_sck <= 1'b0;
            o_oe <= (rd && w != WIDTH_SINGLE) ? 4'h0 : m;
            o_io <= (rd && w != WIDTH_SINGLE) ? ~o_io : 4'(b >> (i * n)) & m;
            repeat (4) @(posedge i_clk);
            o_sck <= 1'b1;
            repeat (2) @(posedge i_clk);
            r = (w == WIDTH_SINGLE) ? {r[6:0], i_io[1]} : 8'((r << n) | 8'(i_io & m));
            repeat (2) @(posedge i_clk);
        end
        if (rd)
            rq.push_back(r);
    endtask

    // Frame: select held low throughout, header, then data bytes
    task automatic frame(input logic rd, input logic ring, input logic [11:0] a, input int n);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        xbyte({rd, ring, 2'h0, a[11:8]}, 1'b0);
        xbyte(a[7:0], 1'b0);
        repeat (n) xbyte(rd ? 8'h00 : wq.pop_front(), rd);
        o_sck <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_oe <= 4'h0;
        o_io <= ~o_io;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

// File: tb_serial_host_port_cmd_fifo.sv
// Purpose: Self-checking bench for the serial host port.
// Assumes: 100 ns core clock, host model on the link.
// Notes: Engine stalls at random; data from an LFSR seeded at 14.
`timescale 1ns/1ns
module tb_serial_host_port_cmd_fifo
    import serial_host_port_pkg::*;
;
    logic i_core_clk, i_rst_n, i_cmd_ready, i_cmd_done, run, sck, cs_n;
    logic o_cmd_valid, o_cmd_pending;
    logic [1:0] i_general_io_drive, i_general_io_oe, o_link_width;
    logic [3:0] h_io, h_oe, pins, o_io, o_io_oe;
    logic [7:0] o_cmd_data, seed, erng;
    logic [7:0] eq[$];
    int err_count = 0;
    int compares = 0;

    // Line level from its driver; inverse of the last value when none drives
    assign pins = (h_oe & h_io) | (~h_oe & o_io_oe & o_io) | (~h_oe & ~o_io_oe & ~h_io);

    serial_host_port_cmd_fifo u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_sck(sck), .i_cs_n(cs_n), .i_io(pins), .o_io(o_io), .o_io_oe(o_io_oe),
        .i_general_io_drive(i_general_io_drive), .i_general_io_oe(i_general_io_oe),
        .o_cmd_valid(o_cmd_valid), .i_cmd_ready(i_cmd_ready), .o_cmd_data(o_cmd_data),
        .i_cmd_done(i_cmd_done), .o_link_width(o_link_width), .o_cmd_pending(o_cmd_pending));
    spi_host_model u_host (.i_clk(i_core_clk), .i_io(pins), .o_sck(sck), .o_cs_n(cs_n),
        .o_io(h_io), .o_oe(h_oe));

    initial
    begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        u_host.wq.push_back(d);
        u_host.frame(1'b0, 1'b0, a, 1);
    endtask

    task automatic rreg(input logic [11:0] a, input logic [7:0] exp);
        u_host.frame(1'b1, 1'b0, a, 1);
        check(u_host.rq.pop_front(), exp);
    endtask

    // Ring bytes first, then the pointer, low byte before high
    task automatic push_cmds(input int n, input logic [11:0] a);
        for (int i = 0; i < n; i++)
        begin
            seed = lfsr(seed);
            u_host.wq.push_back(seed);
            eq.push_back(seed);
        end
        u_host.frame(1'b0, 1'b1, a, n);
        wreg(12'h004, 8'(a + 12'(n)));
        wreg(12'h005, {4'h0, 4'((a + 12'(n)) >> 8)});
    endtask

    task automatic drain;
        int i;
        i = 0;
        while (o_cmd_pending === 1'b1 && i < 3000)
        begin
            @(posedge i_core_clk);
            i++;
        end
        if (i == 3000)
        begin
            err_count++;
            $display("unexpected at %0t: ring never emptied", $time);
            results;
        end
        check({7'h0, o_cmd_pending}, 8'h00);
        check(8'(eq.size()), 8'h00);
    endtask

    // Engine: random stalls, in-order compare, one done per byte taken
    always @(posedge i_core_clk)
    begin
        erng <= lfsr(erng);
        i_cmd_done <= 1'b0;
        i_cmd_ready <= run & erng[0];
        i_general_io_drive <= erng[2:1];
        i_general_io_oe <= erng[4:3];
        if (o_cmd_valid === 1'b1 && i_cmd_ready === 1'b1)
        begin
            check(o_cmd_data, eq.size() > 0 ? eq.pop_front() : ~o_cmd_data);
            i_cmd_done <= 1'b1;
        end
    end

    // Main sequence
    initial
    begin
        i_rst_n = 1'b0;
        run = 1'b0;
        i_cmd_ready = 1'b0;
        i_cmd_done = 1'b0;
        i_general_io_drive = 2'h0;
        i_general_io_oe = 2'h0;
        seed = 8'h0e;
        erng = 8'h0e;
        repeat (10) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        check({6'h00, o_link_width}, 8'h00);
        check({6'h00, o_io_oe[1:0]}, 8'h00);
        check({7'h0, o_cmd_pending}, 8'h00);
        rreg(12'h000, 8'h00);
        wreg(12'h000, 8'h03);
        rreg(12'h000, 8'h00);
        $display("test reset and width done");
        push_cmds(20, 12'h000);
        check({7'h0, o_cmd_pending}, 8'h01);
        run <= 1'b1;
        drain;
        rreg(12'h008, 8'd20);
        wreg(12'h008, 8'h05);
        rreg(12'h008, 8'd20);
        rreg(12'h004, 8'd20);
        rreg(12'h0f0, 8'h00);
        $display("test ring done");
        for (int v = 1; v <= 2; v++)
        begin
            wreg(12'h000, 8'(v));
            u_host.w = width_t'(v);
            check({6'h00, o_link_width}, 8'(v));
            rreg(12'h000, 8'(v));
            push_cmds(3, 12'(17 + 3 * v));
            drain;
        end
        wreg(12'h000, 8'h00);
        u_host.w = WIDTH_SINGLE;
        check({6'h00, o_link_width}, 8'h00);
        rreg(12'h008, 8'd26);
        $display("test wide modes done");
        results;
    end
endmodule
